// file: verification/motor_side_model.sv
// hall sensor and power bridge stand-in for the commutation bench
`timescale 1ns/1ps
`default_nettype none
module motor_side_model (
  // rotor code and hall pins
  input  wire logic [2:0]              code_in,
  output logic                         hall_a_out,
  output logic                         hall_b_out,
  output logic                         hall_c_out,
  // bridge gates
  input  wire commutation_pkg::drive_s drive_in,
  output logic                         shoot_through_out
);
  import commutation_pkg::*;
  logic [2:0] upper_on;
  // push-pull hall outputs always show the code
  assign {hall_a_out, hall_b_out, hall_c_out} = code_in;
  assign upper_on = ~drive_in.top_n;
  // a shared leg or two switches on one rail shorts the supply
  assign shoot_through_out = (|(upper_on & drive_in.bottom)) | ($countones(upper_on) > 1)
                           | ($countones(drive_in.bottom) > 1);
endmodule : motor_side_model
`default_nettype wire

// file: verification/six_step_commutation_decoder_test.sv
// self-checking bench for the six-step commutation decoder
`timescale 1ns/1ps
`default_nettype none
module six_step_commutation_decoder_test;
  import commutation_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic [2:0]  code, oe_n;
  logic        mode, dir, run, oc, ot, ps, hall_a, hall_b, hall_c, shoot, pos_valid, pwm_active;
  drive_s      drive;
  int          num_errors = 0;
  int          checks     = 0;
  logic        sample     = 1'b0;
  logic [31:0] lfsr       = 32'hCC89FA09;
  logic [7:0]  note_q[$];
  logic [2:0]  c60[6]  = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  logic [2:0]  c120[6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  logic [2:0]  bad[4]  = '{3'h5, 3'h2, 3'h7, 3'h0};
  int          up_leg[6] = '{0, 1, 1, 2, 2, 0};
  int          lo_leg[6] = '{2, 2, 0, 0, 1, 1};

  always #12.5 sys_clk_in = ~sys_clk_in;

  six_step_commutation_decoder u_six_step_commutation_decoder (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hall_a_in(hall_a), .hall_b_in(hall_b),
    .hall_c_in(hall_c), .phase_60_sel_in(mode), .rotation_direction_input_in(dir),
    .run_enable_in(run), .overcurrent_in(oc), .over_temp_in(ot), .pwm_stop_in(ps),
    .drive_out(drive), .top_drive_oe_n_out(oe_n), .position_valid_out(pos_valid),
    .pwm_active_out(pwm_active));

  motor_side_model u_motor_side_model (
    .code_in(code), .hall_a_out(hall_a), .hall_b_out(hall_b), .hall_c_out(hall_c),
    .drive_in(drive), .shoot_through_out(shoot));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // reverse swaps the two legs
  function automatic logic [5:0] exp_drive(input int i, input logic d);
    int u, l;
    u = d ? up_leg[i] : lo_leg[i];
    l = d ? lo_leg[i] : up_leg[i];
    return {~(3'h1 << u), 3'h1 << l};
  endfunction : exp_drive

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic fail(input string msg);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic apply(input logic [2:0] c, input logic m, d, r, o, t, p);
    code = c; mode = m; dir = d; run = r; oc = o; ot = t; ps = p;
    repeat (6) @(negedge sys_clk_in);
  endtask : apply

  // three latch-on samples in a row, so the drives already follow it
  task automatic wait_pwm();
    int k, hits;
    hits = 0;
    for (k = 0; k < 2000 && hits < 3; k++) begin
      @(negedge sys_clk_in);
      hits = (pwm_active === 1'b1) ? hits + 1 : 0;
    end
    if (hits < 3) begin
      fail("pwm latch never set");
      complete_run();
    end
  endtask : wait_pwm

  // note = {valid matters, valid, drive}
  task automatic expect_out(input logic [5:0] drv, input logic care, input logic pv);
    note_q.push_back({care, pv, drv});
    sample <= 1'b1;
    @(negedge sys_clk_in);
    sample <= 1'b0;
  endtask : expect_out

  task automatic check_out(input logic [7:0] n);
    checks++;
    if (drive !== n[5:0] || oe_n !== n[5:3] || shoot !== 1'b0 || (n[7] && pos_valid !== n[6]))
      fail($sformatf("drive %h valid %b expected %h", drive, pos_valid, n[6:0]));
  endtask : check_out

  always @(negedge sys_clk_in) begin
    if (sample) begin
      if (note_q.size() == 0)
        fail("result without note");
      else
        check_out(note_q.pop_front());
    end
  end

  initial begin
    int m, d, i, k;
    code = 3'h4; mode = 1'b1; dir = 1'b1; run = 1'b1; oc = 1'b0; ot = 1'b0; ps = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    expect_out(DRIVE_OFF, 1'b1, 1'b0);
    repeat (7) @(negedge sys_clk_in);
    rst_in = 1'b0;
    for (m = 0; m < 2; m++)
      for (d = 0; d < 2; d++)
        for (i = 0; i < 6; i++) begin
          apply(m[0] ? c60[i] : c120[i], m[0], d[0], 1'b1, 1'b0, 1'b0, 1'b0);
          wait_pwm();
          expect_out(exp_drive(i, d[0]), 1'b1, 1'b1);
        end
    $display("step tables done");
    for (i = 0; i < 4; i++) begin
      apply(bad[i], i < 2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      wait_pwm();
      expect_out(DRIVE_OFF, 1'b1, 1'b0);
    end
    $display("invalid codes done");
    // gate by run low, then overcurrent held, then over-temperature
    for (k = 0; k < 3; k++) begin
      apply(c60[k], 1'b1, 1'b1, k != 0, k == 1, k == 2, 1'b0);
      repeat (OSC_CYCLES + 8) @(negedge sys_clk_in);
      expect_out(DRIVE_OFF, 1'b0, 1'b0);
    end
    $display("gating done");
    // short overcurrent or stop pulse ends this cycle's conduction only
    for (k = 0; k < 2; k++) begin
      apply(c60[2], 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      wait_pwm();
      oc = (k == 0);
      ps = (k == 1);
      repeat (3) @(negedge sys_clk_in);
      oc = 1'b0;
      ps = 1'b0;
      repeat (8) @(negedge sys_clk_in);
      expect_out(DRIVE_OFF, 1'b1, 1'b1);
      wait_pwm();
      expect_out(exp_drive(2, 1'b1), 1'b1, 1'b1);
    end
    $display("latch done");
    for (k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      i = lfsr[15:0] % 6;
      apply(lfsr[20] ? c60[i] : c120[i], lfsr[20], lfsr[21], 1'b1, 1'b0, 1'b0, 1'b0);
      wait_pwm();
      expect_out(exp_drive(i, lfsr[21]), 1'b1, 1'b1);
    end
    $display("random steps done");
    complete_run();
  end
endmodule : six_step_commutation_decoder_test
`default_nettype wire

// file: verilog/commutation_pkg.sv
// shared constants, carriers and decode functions for the six-step commutation decoder
package commutation_pkg;

  // timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int OSC_PERIOD_NS   = 40000;
  localparam int OSC_FALL_NS     = 2000;
  localparam int OSC_CYCLES      = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_FALL_CYCLES = OSC_FALL_NS / CLK_PERIOD_NS;
  localparam int OSC_CNT_W       = 11;
  localparam logic [OSC_CNT_W-1:0] OSC_LAST     = OSC_CNT_W'(OSC_CYCLES - 1);
  localparam logic [OSC_CNT_W-1:0] OSC_RAMP_END = OSC_CNT_W'(OSC_CYCLES - OSC_FALL_CYCLES);
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_RESET = 11'h000;

  // synchronised pin group
  typedef struct packed {
    logic hall_a;
    logic hall_b;
    logic hall_c;
    logic phase_60;
    logic rotation_direction_input;
    logic run_enable;
    logic overcurrent;
    logic over_temp;
    logic pwm_stop;
  } pins_s;

  localparam int         PINS_W     = $bits(pins_s);
  localparam logic [8:0] PINS_RESET = 9'h000;

  // drive group: top legs active low, bottom legs active high, bit 0 = leg A
  typedef struct packed {
    logic [2:0] top_n;
    logic [2:0] bottom;
  } drive_s;

  localparam logic [5:0] DRIVE_OFF = 6'h38;

  // six drive steps, named top leg then bottom leg
  typedef enum logic [2:0] {
    STEP_AC,
    STEP_BC,
    STEP_BA,
    STEP_CA,
    STEP_CB,
    STEP_AB,
    STEP_NONE
  } step_e;

  // sensor code {a,b,c} to drive step; two codes per phasing are invalid
  function automatic step_e decode_step(input logic [2:0] code, input logic mode_60);
    step_e s;
    s = STEP_NONE;
    if (mode_60) begin
      case (code)
        3'h4:    s = STEP_AC;
        3'h6:    s = STEP_BC;
        3'h7:    s = STEP_BA;
        3'h3:    s = STEP_CA;
        3'h1:    s = STEP_CB;
        3'h0:    s = STEP_AB;
        default: s = STEP_NONE;
      endcase
    end else begin
      case (code)
        3'h4:    s = STEP_AC;
        3'h6:    s = STEP_BC;
        3'h2:    s = STEP_BA;
        3'h3:    s = STEP_CA;
        3'h1:    s = STEP_CB;
        3'h5:    s = STEP_AB;
        default: s = STEP_NONE;
      endcase
    end
    return s;
  endfunction : decode_step

  // one-hot leg of the upper or lower switch for a step
  function automatic logic [2:0] leg_mask(input step_e s, input logic upper);
    logic [2:0] m;
    m = 3'h0;
    case (s)
      STEP_AC: m = upper ? 3'h1 : 3'h4;
      STEP_BC: m = upper ? 3'h2 : 3'h4;
      STEP_BA: m = upper ? 3'h2 : 3'h1;
      STEP_CA: m = upper ? 3'h4 : 3'h1;
      STEP_CB: m = upper ? 3'h4 : 3'h2;
      STEP_AB: m = upper ? 3'h1 : 3'h2;
      default: m = 3'h0;
    endcase
    return m;
  endfunction : leg_mask

endpackage : commutation_pkg

// file: verilog/pin_filter_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_filter_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // pins and filtered result
  input  wire logic [WIDTH-1:0] pins_in,
  output var  logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  wire logic [WIDTH-1:0] level_next;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end else begin
      stage1_reg <= pins_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a bit only moves once stages two and three agree, so one-cycle glitches die here
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign level_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : level_out[i];
    end
  endgenerate

  // one process owns the whole filtered word, so no bit has two writers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= RESET_VAL;
    end else begin
      level_out <= level_next;
    end
  end

endmodule : pin_filter_sync
`default_nettype wire

// file: verilog/six_step_commutation_decoder.sv
// six-step commutation decoder with pwm latch and protection gating
// Summary of operation
// - valid code: one upper, one lower, different legs
// - six drive steps per electrical cycle, full wave
// - 60 forward order 100,110,111,011,001,000
// - 120 forward order 100,110,010,011,001,101
// - phase select high 60 table, low 120
// - over-temperature switches every drive off
// - invalid sensor code switches every drive off
// - run low or overcurrent switches drives off
// - one pulse per cycle, overcurrent holds off
// - upper drive outputs are active low
`timescale 1ns/1ps
`default_nettype none
module six_step_commutation_decoder (
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  // hall sensors
  input  wire logic                   hall_a_in,
  input  wire logic                   hall_b_in,
  input  wire logic                   hall_c_in,
  // configuration and control pins
  input  wire logic                   phase_60_sel_in,
  input  wire logic                   rotation_direction_input_in,
  input  wire logic                   run_enable_in,
  // protection and pwm comparator pins
  input  wire logic                   overcurrent_in,
  input  wire logic                   over_temp_in,
  input  wire logic                   pwm_stop_in,
  // drives to the power bridge
  output var  commutation_pkg::drive_s drive_out,
  output var  logic [2:0]             top_drive_oe_n_out,
  // status
  output var  logic                   position_valid_out,
  output var  logic                   pwm_active_out
);
  import commutation_pkg::*;

  pins_s                 pins_raw;
  pins_s                 pins;
  logic [OSC_CNT_W-1:0]  osc_cnt_reg;
  logic                  cycle_start;
  logic                  pwm_on_reg;
  step_e                 step_now;
  logic                  drive_enable;
  drive_s                drive_next;

  // everything here arrives from pins, so it all crosses through the filter
  assign pins_raw = '{hall_a:                   hall_a_in,
                      hall_b:                   hall_b_in,
                      hall_c:                   hall_c_in,
                      phase_60:                 phase_60_sel_in,
                      rotation_direction_input: rotation_direction_input_in,
                      run_enable:               run_enable_in,
                      overcurrent:              overcurrent_in,
                      over_temp:                over_temp_in,
                      pwm_stop:                 pwm_stop_in};

  pin_filter_sync #(
    .WIDTH     (PINS_W),
    .RESET_VAL (PINS_RESET)
  ) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pins_in    (pins_raw),
    .level_out  (pins)
  );

  // oscillator cycle divider
  assign cycle_start = (osc_cnt_reg == OSC_CNT_RESET);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_cnt_reg <= OSC_CNT_RESET;
    end else if (osc_cnt_reg == OSC_LAST) begin
      osc_cnt_reg <= OSC_CNT_RESET;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 11'h001;
    end
  end

  // pwm latch: set only at cycle start, once cleared it waits for the next start
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_on_reg <= 1'b0;
    end else if (cycle_start) begin
      pwm_on_reg <= !pins.overcurrent;
    end else if (pins.overcurrent || pins.pwm_stop || osc_cnt_reg >= OSC_RAMP_END) begin
      pwm_on_reg <= 1'b0;
    end
  end

  // position decode, phasing chosen by the strap level
  assign step_now = decode_step({pins.hall_a, pins.hall_b, pins.hall_c}, pins.phase_60);

  // overcurrent also gates directly so the trip cycle itself is cut
  assign drive_enable = pins.run_enable && !pins.overcurrent && !pins.over_temp
                        && pwm_on_reg && (step_now != STEP_NONE);

  // reverse swaps upper and lower legs of the same step
  always_comb begin
    drive_next = DRIVE_OFF;
    if (drive_enable) begin
      if (pins.rotation_direction_input) begin
        drive_next.top_n  = ~leg_mask(step_now, 1'b1);
        drive_next.bottom = leg_mask(step_now, 1'b0);
      end else begin
        drive_next.top_n  = ~leg_mask(step_now, 1'b0);
        drive_next.bottom = leg_mask(step_now, 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_out          <= DRIVE_OFF;
      top_drive_oe_n_out <= DRIVE_OFF[5:3];
    end else begin
      drive_out          <= drive_next;
      top_drive_oe_n_out <= drive_next.top_n;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      position_valid_out <= 1'b0;
    end else begin
      position_valid_out <= (step_now != STEP_NONE);
    end
  end

  assign pwm_active_out = pwm_on_reg;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_gated_on;
    pins.run_enable && !pins.overcurrent && !pins.over_temp && pwm_on_reg;
  endsequence

  sequence seq_all_off;
    drive_out.top_n == 3'h7 && drive_out.bottom == 3'h0;
  endsequence

  chk_one_pair_legs: assert property (
    seq_gated_on ##0 (step_now != STEP_NONE) |=> $onehot(~drive_out.top_n) && $onehot(drive_out.bottom)
      && ((~drive_out.top_n & drive_out.bottom) == 3'h0))
    else $error("drive pair not one upper and one lower on different legs");

  chk_step_advance: assert property (
    seq_gated_on ##0 (step_now == STEP_AC) && pins.rotation_direction_input
      ##1 seq_gated_on ##0 (step_now == STEP_BC) && pins.rotation_direction_input
      |=> drive_out.top_n == 3'h5 && drive_out.bottom == 3'h4 && $past(drive_out.top_n) == 3'h6)
    else $error("drive did not follow the step change");

  chk_sixty_forward: assert property (
    seq_gated_on ##0 pins.phase_60 && pins.rotation_direction_input
      && {pins.hall_a, pins.hall_b, pins.hall_c} == 3'h7
      |=> drive_out.top_n == 3'h5 && drive_out.bottom == 3'h1)
    else $error("60 degree code 111 not decoded to upper B lower A");

  chk_onetwenty_fwd: assert property (
    seq_gated_on ##0 !pins.phase_60 && pins.rotation_direction_input
      && {pins.hall_a, pins.hall_b, pins.hall_c} == 3'h2
      |=> drive_out.top_n == 3'h5 && drive_out.bottom == 3'h1)
    else $error("120 degree code 010 not decoded to upper B lower A");

  chk_phase_strap: assert property (
    {pins.hall_a, pins.hall_b, pins.hall_c} == 3'h0 |-> (step_now == STEP_NONE) == !pins.phase_60)
    else $error("code 000 validity does not follow the phasing strap");

  chk_over_temp_off: assert property (
    pins.over_temp |=> seq_all_off)
    else $error("drives on during over-temperature");

  chk_invalid_off: assert property (
    step_now == STEP_NONE |=> seq_all_off and (!position_valid_out))
    else $error("drives on with an invalid sensor code");

  chk_run_sense_off: assert property (
    !pins.run_enable || pins.overcurrent |=> seq_all_off)
    else $error("drives on with run low or overcurrent");

  chk_trip_holds_off: assert property (
    pins.overcurrent && !cycle_start ##1 !cycle_start |-> !pwm_on_reg)
    else $error("pwm latch released before the next cycle start");

  chk_one_pulse: assert property (
    $fell(pwm_on_reg) ##1 !cycle_start |-> !pwm_on_reg)
    else $error("second conduction pulse within one oscillator cycle");

  chk_upper_low_on: assert property (
    seq_gated_on ##0 step_now == STEP_AC && pins.rotation_direction_input
      |=> drive_out.top_n == 3'h6 && top_drive_oe_n_out == 3'h6)
    else $error("upper drive for leg A not pulled low");

  chk_reverse_map: assert property (
    seq_gated_on ##0 step_now == STEP_AC && !pins.rotation_direction_input
      |=> drive_out.top_n == 3'h3 && drive_out.bottom == 3'h1)
    else $error("reverse mapping for code 100 not upper C lower A");

  chk_reverse_lower: assert property (
    seq_gated_on ##0 step_now == STEP_CB && !pins.rotation_direction_input
      |=> drive_out.top_n == 3'h5 && drive_out.bottom == 3'h4)
    else $error("reverse mapping for code 001 not upper B lower C");

  chk_valid_flag: assert property (
    step_now != STEP_NONE |=> position_valid_out)
    else $error("position valid flag low for a valid sensor code");

  chk_latch_sets: assert property (
    cycle_start && !pins.overcurrent |=> pwm_on_reg)
    else $error("pwm latch not set at oscillator cycle start");

  chk_ramp_end_off: assert property (
    osc_cnt_reg >= OSC_RAMP_END |=> !pwm_on_reg)
    else $error("pwm latch still set after the ramp-up period");

  chk_open_collector: assert property (
    top_drive_oe_n_out == drive_out.top_n)
    else $error("upper drive enable differs from the upper drive level");

endmodule : six_step_commutation_decoder
`default_nettype wire
